/* File: design/bocy_params.svh */
`ifndef BOCY_PARAMS_SVH
`define BOCY_PARAMS_SVH
// Cycle-type codes, valid only with the address strobe
`define BOCY_CT_PROG_8 4'h0
`define BOCY_CT_PROG_16 4'h1
`define BOCY_CT_PROG_32 4'h2
`define BOCY_CT_EVT_8 4'h4
`define BOCY_CT_EVT_16 4'h5
`define BOCY_CT_EVT_32 4'h6
`define BOCY_CT_IDLE 4'h0
// Bus width selector encodings
`define BOCY_W8 2'h0
`define BOCY_W16 2'h1
`define BOCY_W32 2'h2
// Reset values
`define BOCY_ADDR_RST 32'h00000000
`define BOCY_DATA_RST 32'h00000000
`endif

/* File: design/bocy_pkg.sv */
package bocy_pkg;
  typedef enum logic [4:0] {
    BOCY_HOLD = 5'h01,
    BOCY_IDLE = 5'h02,
    BOCY_ADDR = 5'h04,
    BOCY_DATA = 5'h08,
    BOCY_BUS_BACKOFF_REQ = 5'h10
  } bocy_state_t;
endpackage

/* File: design/bocy_sync.sv */
// ----------------------------------------
// Two-stage synchroniser, one per bit
// ----------------------------------------
module bocy_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic stage1_reg;
      logic stage2_reg;
      // First stage feeds only the second
      always_ff @(posedge clk) begin
        if (rst) begin
          stage1_reg <= 1'b0;
          stage2_reg <= 1'b0;
        end else begin
          stage1_reg <= async_in[i];
          stage2_reg <= stage1_reg;
        end
      end
      assign sync_out[i] = stage2_reg;
    end
  endgenerate
endmodule

/* File: design/bocy_bus_owner.sv */
// Overview of operation
// R1 - On hold request, finish current request, then grant hold and float buses.
// R2 - Hold withdrawn: drop grant and drive address, data, control again.
// R3 - While reset is active, grant hold and stay in hold state.
// R4 - Never raise hold grant while the atomic lock is active.
// R5 - Back-off floats buses next clock and aborts the access in progress.
// R6 - After back-off release, reissue the aborted access from its start.
// R7 - Demand pending output is high whenever a request is outstanding.
// R8 - Stall output is high while the core waits on a bus result.
// R9 - Program accesses drive codes 0000, 0001, 0010 for 8, 16, 32 bits.
// R10 - Event accesses drive codes 0100, 0101, 0110 for 8, 16, 32 bits.
// R11 - No reserved code, and no code at all without address strobe.
// R12 - Address strobe is high only in the first clock of each access.
// R13 - Lock rises at atomic start, clears when final transfer drops at end.
// R14 - Hold and back-off are synchronised; back-off beats hold.
`include "bocy_params.svh"
module bocy_bus_owner (
  input wire logic clk,
  input wire logic rst,
  // Pins from the outside master
  input wire logic hold_req,
  input wire logic bus_backoff_req,
  input wire logic ready_in,
  // Core request port
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [31:0] req_addr,
  input wire logic [31:0] req_wdata,
  input wire logic req_write,
  input wire logic req_event,
  input wire logic req_atomic,
  input wire logic req_last,
  input wire logic [1:0] req_width,
  input wire logic core_waiting,
  output logic done_pulse,
  // Bus pins
  output logic hold_grant,
  output logic bus_demand_pending,
  output logic core_bus_stall,
  output logic addr_strobe,
  output logic final_transfer,
  output logic atomic_lock,
  output logic [3:0] cycle_kind_code,
  output logic [31:0] addr_out,
  output logic [31:0] data_out,
  output logic write_out,
  output logic bus_oe
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0] sync_q;
  logic hold_s;
  logic bus_backoff_req_s;
  logic ready_s;
  logic ready_q1_reg;
  logic ready_q2_reg;

  bocy_sync #(.WIDTH(2)) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({bus_backoff_req, hold_req}),
    .sync_out(sync_q)
  );
  assign hold_s = sync_q[0]; // [R14]
  assign bus_backoff_req_s = sync_q[1]; // [R14]

  // Ready also crosses in from the pins
  always_ff @(posedge clk) begin
    if (rst) begin
      ready_q1_reg <= 1'b0;
      ready_q2_reg <= 1'b0;
    end else begin
      ready_q1_reg <= ready_in;
      ready_q2_reg <= ready_q1_reg;
    end
  end
  assign ready_s = ready_q2_reg;

  // ----------------------------------------
  // Ownership state machine
  // ----------------------------------------
  bocy_pkg::bocy_state_t state_reg;
  bocy_pkg::bocy_state_t state_next;
  logic pend_reg;
  logic lock_reg;
  logic [31:0] addr_reg;
  logic [31:0] data_reg;
  logic write_reg;
  logic event_reg;
  logic atomic_reg;
  logic last_reg;
  logic [1:0] width_reg;
  logic take;

  assign req_ready = !pend_reg && !rst;
  assign take = req_valid && req_ready;

  // Next state; back-off outranks hold, lock blocks hold
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      bocy_pkg::BOCY_HOLD: begin
        if (!hold_s) begin
          state_next = bocy_pkg::BOCY_IDLE; // [R2]
        end
      end
      bocy_pkg::BOCY_IDLE: begin
        if (bus_backoff_req_s) begin
          state_next = bocy_pkg::BOCY_BUS_BACKOFF_REQ; // [R14]
        end else if (hold_s && !lock_reg) begin
          state_next = bocy_pkg::BOCY_HOLD; // [R1] [R4]
        end else if (pend_reg) begin
          state_next = bocy_pkg::BOCY_ADDR;
        end
      end
      bocy_pkg::BOCY_ADDR: begin
        if (bus_backoff_req_s) begin
          state_next = bocy_pkg::BOCY_BUS_BACKOFF_REQ; // [R5]
        end else begin
          state_next = bocy_pkg::BOCY_DATA;
        end
      end
      bocy_pkg::BOCY_DATA: begin
        if (bus_backoff_req_s) begin
          state_next = bocy_pkg::BOCY_BUS_BACKOFF_REQ; // [R5]
        end else if (ready_s) begin
          state_next = bocy_pkg::BOCY_IDLE; // [R1]
        end
      end
      bocy_pkg::BOCY_BUS_BACKOFF_REQ: begin
        if (!bus_backoff_req_s) begin
          state_next = bocy_pkg::BOCY_IDLE; // [R6]
        end
      end
      default: state_next = bocy_pkg::BOCY_HOLD;
    endcase
  end

  // State register; reset parks in hold-granted
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= bocy_pkg::BOCY_HOLD; // [R3]
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Request capture and completion
  // ----------------------------------------
  // Pending request stays latched until its data cycle completes
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_reg <= 1'b0;
      addr_reg <= `BOCY_ADDR_RST;
      data_reg <= `BOCY_DATA_RST;
      write_reg <= 1'b0;
      event_reg <= 1'b0;
      atomic_reg <= 1'b0;
      last_reg <= 1'b0;
      width_reg <= `BOCY_W32;
    end else if (take) begin
      pend_reg <= 1'b1;
      addr_reg <= req_addr;
      data_reg <= req_wdata;
      write_reg <= req_write;
      event_reg <= req_event;
      atomic_reg <= req_atomic;
      last_reg <= req_last;
      width_reg <= req_width;
    end else if (state_reg == bocy_pkg::BOCY_DATA && ready_s && !bus_backoff_req_s) begin
      pend_reg <= 1'b0; // Aborted accesses keep pend_reg and replay [R6]
    end
  end

  // One-cycle completion pulse to the core
  always_ff @(posedge clk) begin
    if (rst) begin
      done_pulse <= 1'b0;
    end else begin
      done_pulse <= (state_reg == bocy_pkg::BOCY_DATA) && ready_s && !bus_backoff_req_s;
    end
  end

  // Atomic lock: set at first address of atomic op, clear after its last transfer
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_reg <= 1'b0;
    end else if (state_reg == bocy_pkg::BOCY_ADDR && atomic_reg) begin
      lock_reg <= 1'b1; // [R13]
    end else if (state_reg == bocy_pkg::BOCY_DATA && ready_s && !bus_backoff_req_s && last_reg) begin
      lock_reg <= 1'b0; // [R13]
    end
  end

  // ----------------------------------------
  // Output drive
  // ----------------------------------------
  logic [3:0] code_sel;
  // Cycle-type code from origin and width; reserved codes never formed
  always_comb begin
    case (width_reg)
      `BOCY_W8: code_sel = event_reg ? `BOCY_CT_EVT_8 : `BOCY_CT_PROG_8; // [R9] [R10]
      `BOCY_W16: code_sel = event_reg ? `BOCY_CT_EVT_16 : `BOCY_CT_PROG_16; // [R9] [R10]
      default: code_sel = event_reg ? `BOCY_CT_EVT_32 : `BOCY_CT_PROG_32; // [R9] [R10]
    endcase
  end

  // Registered bus outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_strobe <= 1'b0;
      cycle_kind_code <= `BOCY_CT_IDLE;
      final_transfer <= 1'b0;
      addr_out <= `BOCY_ADDR_RST;
      data_out <= `BOCY_DATA_RST;
      write_out <= 1'b0;
    end else begin
      addr_strobe <= (state_next == bocy_pkg::BOCY_ADDR); // [R12]
      cycle_kind_code <= (state_next == bocy_pkg::BOCY_ADDR) ? code_sel
                         : `BOCY_CT_IDLE; // [R11]
      final_transfer <= (state_next == bocy_pkg::BOCY_DATA) && last_reg;
      addr_out <= addr_reg;
      data_out <= data_reg;
      write_out <= write_reg;
    end
  end

  assign hold_grant = (state_reg == bocy_pkg::BOCY_HOLD) && !lock_reg; // [R1] [R3] [R4]
  assign bus_oe = (state_reg != bocy_pkg::BOCY_HOLD)
                  && (state_reg != bocy_pkg::BOCY_BUS_BACKOFF_REQ); // [R1] [R2] [R5]
  assign atomic_lock = lock_reg;
  assign bus_demand_pending = pend_reg; // [R7]
  assign core_bus_stall = pend_reg && core_waiting; // [R8]

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_grant_no_lock: assert property (@(posedge clk) disable iff (rst)
    !(hold_grant && atomic_lock)) // [R4]
    else $error("hold grant raised under lock");
  a_reset_grant: assert property (@(posedge clk)
    $past(rst) |-> hold_grant) // [R3]
    else $error("no hold grant during reset");
  a_bus_backoff_req_float: assert property (@(posedge clk) disable iff (rst)
    (bus_backoff_req_s && state_reg != bocy_pkg::BOCY_HOLD) |=> !bus_oe) // [R5]
    else $error("buses not floated after back-off");
  a_strobe_single: assert property (@(posedge clk) disable iff (rst)
    addr_strobe |=> !addr_strobe) // [R12]
    else $error("address strobe longer than one clock");
  a_code_quiet: assert property (@(posedge clk) disable iff (rst)
    !addr_strobe |-> cycle_kind_code == 4'h0) // [R11]
    else $error("code driven without strobe");
  a_code_legal: assert property (@(posedge clk) disable iff (rst)
    addr_strobe |-> (cycle_kind_code[1:0] != 2'h3 && !cycle_kind_code[3])) // [R11]
    else $error("reserved cycle code");
  a_prog_code: assert property (@(posedge clk) disable iff (rst)
    (addr_strobe && !event_reg) |-> !cycle_kind_code[2]) // [R9]
    else $error("program access with event code");
  a_evt_code: assert property (@(posedge clk) disable iff (rst)
    (addr_strobe && event_reg) |-> cycle_kind_code[2]) // [R10]
    else $error("event access with program code");
  a_hold_release: assert property (@(posedge clk) disable iff (rst)
    (state_reg == bocy_pkg::BOCY_HOLD && !hold_s) |=> !hold_grant && bus_oe) // [R2]
    else $error("hold not released");
  a_replay: assert property (@(posedge clk) disable iff (rst)
    (state_reg == bocy_pkg::BOCY_BUS_BACKOFF_REQ && !bus_backoff_req_s && pend_reg && !hold_s)
    |=> pend_reg ##1 addr_strobe) // [R6]
    else $error("aborted access not replayed");
  a_demand: assert property (@(posedge clk) disable iff (rst)
    take |=> bus_demand_pending) // [R7]
    else $error("demand not shown");
  a_ready_block: assert property (@(posedge clk) disable iff (rst)
    bus_demand_pending |-> !req_ready) // [R7]
    else $error("request taken while one is pending");
  a_lock_rise: assert property (@(posedge clk) disable iff (rst)
    (state_reg == bocy_pkg::BOCY_ADDR && atomic_reg) |=> atomic_lock) // [R13]
    else $error("lock not raised at atomic start");
  a_lock_clear: assert property (@(posedge clk) disable iff (rst)
    (state_reg == bocy_pkg::BOCY_DATA && ready_s && !bus_backoff_req_s && last_reg) |=> !atomic_lock) // [R13]
    else $error("lock not cleared after last transfer");
  a_final_data: assert property (@(posedge clk) disable iff (rst)
    final_transfer |-> state_reg == bocy_pkg::BOCY_DATA) // [R13]
    else $error("final transfer outside data cycle");
  a_strobe_addr: assert property (@(posedge clk) disable iff (rst)
    addr_strobe |-> state_reg == bocy_pkg::BOCY_ADDR) // [R12]
    else $error("address strobe outside address cycle");
  a_bus_backoff_req_abort: assert property (@(posedge clk) disable iff (rst)
    (state_reg == bocy_pkg::BOCY_DATA && bus_backoff_req_s) |=> !done_pulse) // [R5]
    else $error("aborted access reported done");
  a_hold_float: assert property (@(posedge clk) disable iff (rst)
    hold_grant |-> !bus_oe) // [R1]
    else $error("buses driven while hold granted");
  a_bus_backoff_req_beats: assert property (@(posedge clk) disable iff (rst)
    (bus_backoff_req_s && hold_s && state_reg == bocy_pkg::BOCY_IDLE) |=> state_reg == bocy_pkg::BOCY_BUS_BACKOFF_REQ) // [R14]
    else $error("hold won over back-off");
  a_no_grant_mid: assert property (@(posedge clk) disable iff (rst)
    (state_reg == bocy_pkg::BOCY_ADDR || state_reg == bocy_pkg::BOCY_DATA) |=> !hold_grant) // [R1]
    else $error("hold granted inside an access");
  a_stall_level: assert property (@(posedge clk) disable iff (rst)
    (bus_demand_pending && core_waiting) |-> core_bus_stall) // [R8]
    else $error("stall not shown while core waits");
  a_stall_clear: assert property (@(posedge clk) disable iff (rst)
    !bus_demand_pending |-> !core_bus_stall) // [R8]
    else $error("stall without outstanding request");
  a_stall: assert property (@(posedge clk) disable iff (rst)
    core_bus_stall |-> bus_demand_pending) // [R8]
    else $error("stall without pending request");

  c_hold: cover property (@(posedge clk) disable iff (rst) $rose(hold_grant));
  c_bus_backoff_req: cover property (@(posedge clk) disable iff (rst)
    state_reg == bocy_pkg::BOCY_BUS_BACKOFF_REQ ##1 state_reg == bocy_pkg::BOCY_IDLE);
  c_lock: cover property (@(posedge clk) disable iff (rst) $fell(atomic_lock));
  c_event: cover property (@(posedge clk) disable iff (rst) addr_strobe && event_reg);
endmodule

/* File: testbench/bocy_ext_master.sv */
// ----------------------------------------
// Outside master: hold, back-off, ready
// ----------------------------------------
module bocy_ext_master (
  input wire logic clk,
  input wire logic addr_strobe,
  input wire logic want_hold,
  input wire logic want_bus_backoff_req,
  input wire logic slow,
  output logic hold_req,
  output logic bus_backoff_req,
  output logic ready_in
);
  timeunit 1ns;
  timeprecision 1ns;
  int wait_cnt = -1;
  // Quiet pins at time zero
  initial begin
    hold_req = 1'b0;
    bus_backoff_req = 1'b0;
    ready_in = 1'b0;
  end
  // Pins change on the falling edge; ready is a one-cycle answer
  always @(negedge clk) begin
    hold_req <= want_hold;
    bus_backoff_req <= want_bus_backoff_req;
    ready_in <= (wait_cnt == 0) && !want_bus_backoff_req;
    if (want_bus_backoff_req) begin
      wait_cnt <= -1; // An aborted access gets no answer
    end else if (addr_strobe) begin
      wait_cnt <= slow ? 6 : 1;
    end else if (wait_cnt >= 0) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule

/* File: testbench/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, hold_req, bus_backoff_req, ready_in, req_valid, req_ready, req_write;
  logic req_event, req_atomic, req_last, core_waiting, done_pulse, hold_grant;
  logic bus_demand_pending, core_bus_stall, addr_strobe, final_transfer, atomic_lock;
  logic write_out, bus_oe, want_hold, want_bus_backoff_req, slow;
  logic [31:0] req_addr, req_wdata, addr_out, data_out;
  logic [1:0] req_width;
  logic [3:0] cycle_kind_code;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  bocy_bus_owner dut (.*);
  bocy_ext_master far_end (.*);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_for(ref logic sig, input string msg);
    int n;
    n = 0;
    while (sig !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk(sig, 1'b1, msg);
  endtask
  // Issue one access and judge its address cycle
  task automatic go(input logic ev, input logic [1:0] w, input logic at, input logic last,
                    input logic [31:0] a);
    req_valid = 1'b1;
    req_event = ev;
    req_width = w;
    req_atomic = at;
    req_last = last;
    req_addr = a;
    req_wdata = ~a;
    req_write = a[4];
    wait_for(req_ready, "ready");
    tick(1);
    req_valid = 1'b0;
    wait_for(addr_strobe, "strobe");
    chk(cycle_kind_code, {1'b0, ev, w}, "code");
    chk(addr_out, a, "addr");
    chk(bus_demand_pending, 1'b1, "pending");
    chk(core_bus_stall, core_waiting, "stall");
    tick(1);
    chk(addr_strobe, 1'b0, "strobe width");
    chk(cycle_kind_code, 4'h0, "code off strobe");
    chk(final_transfer, last, "final");
  endtask
  task automatic fin();
    wait_for(done_pulse, "done");
    tick(1);
    chk(bus_demand_pending, 1'b0, "pending end");
    chk(core_bus_stall, 1'b0, "stall end");
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_codes();
    for (int e = 0; e < 2; e++) begin
      for (int w = 0; w < 3; w++) begin
        core_waiting = e[0];
        go(e[0], w[1:0], 1'b0, 1'b0, 32'h1000 + w * 16 + e);
        fin();
      end
    end
    core_waiting = 1'b0;
  endtask
  task automatic t_hold();
    slow = 1'b1;
    go(1'b0, 2'h2, 1'b0, 1'b0, 32'h2000);
    want_hold = 1'b1;
    tick(4);
    chk(hold_grant, 1'b0, "grant mid access");
    fin();
    tick(4);
    chk(hold_grant, 1'b1, "grant");
    chk(bus_oe, 1'b0, "float");
    want_hold = 1'b0;
    tick(5);
    chk(hold_grant, 1'b0, "grant drop");
    chk(bus_oe, 1'b1, "drive");
    slow = 1'b0;
  endtask
  task automatic t_lock();
    go(1'b0, 2'h2, 1'b1, 1'b0, 32'h3000);
    chk(atomic_lock, 1'b1, "lock");
    want_hold = 1'b1;
    fin();
    tick(5);
    chk(hold_grant, 1'b0, "grant under lock");
    chk(atomic_lock, 1'b1, "lock held");
    want_hold = 1'b0;
    tick(5);
    go(1'b0, 2'h2, 1'b1, 1'b1, 32'h3004);
    fin();
    chk(atomic_lock, 1'b0, "lock clear");
  endtask
  task automatic t_bus_backoff_req();
    slow = 1'b1;
    go(1'b1, 2'h1, 1'b0, 1'b0, 32'h4000);
    tick(1);
    want_bus_backoff_req = 1'b1;
    tick(4);
    chk(bus_oe, 1'b0, "backoff float");
    chk(done_pulse, 1'b0, "no done");
    want_bus_backoff_req = 1'b0;
    wait_for(addr_strobe, "replay");
    chk(addr_out, 32'h4000, "replay addr");
    chk(cycle_kind_code, 4'h5, "replay code");
    slow = 1'b0;
    fin();
    want_hold = 1'b1;
    want_bus_backoff_req = 1'b1;
    tick(6);
    chk(hold_grant, 1'b0, "backoff beats hold");
    chk(bus_oe, 1'b0, "both float");
    want_hold = 1'b0;
    want_bus_backoff_req = 1'b0;
    tick(6);
    chk(bus_oe, 1'b1, "drive again");
  endtask
  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    {rst, req_valid, req_write, req_event, req_atomic, req_last} = 6'h20;
    {core_waiting, want_hold, want_bus_backoff_req, slow} = 4'h0;
    {req_addr, req_wdata, req_width} = '0;
    tick(12);
    chk(hold_grant, 1'b1, "reset grant");
    chk(bus_oe, 1'b0, "reset float");
    rst = 1'b0;
    tick(6);
    t_codes();
    t_hold();
    t_lock();
    t_bus_backoff_req();
    conclude();
  end
endmodule
